/* File: rtl/mcsfr_cfg.svh */
// Offsets, bit positions, reset values and timing counts of the register bank.
// Assumes a 25 MHz core clock and a byte-wide register bus.
`ifndef MCSFR_CFG_SVH
`define MCSFR_CFG_SVH
`define MCSFR_OFF_PORT0_PULLUP_CTRL 8'h86
`define MCSFR_OFF_PWR 8'h87
`define MCSFR_OFF_AUX 8'h8E
`define MCSFR_OFF_SLAVE_ADDRESS 8'hA9
`define MCSFR_OFF_SMASK 8'hB9
`define MCSFR_OFF_PROG 8'hBF
`define MCSFR_OFF_XIC 8'hC0
`define MCSFR_OFF_TAKEY 8'hC7
`define MCSFR_OFF_TIMER_TWO_CONTROL_REG 8'hC8
`define MCSFR_OFF_RLDL 8'hCA
`define MCSFR_OFF_RLDH 8'hCB
`define MCSFR_OFF_CNTL 8'hCC
`define MCSFR_OFF_CNTH 8'hCD
`define MCSFR_OFF_PSW 8'hD0
`define MCSFR_OFF_COUNTER_ARRAY_MODE 8'hD9
`define MCSFR_AUX_DIS_BIT 1
`define MCSFR_PWR_BAUD_BIT 7
`define MCSFR_PWR_FE_BIT 6
`define MCSFR_PWR_POF_BIT 4
`define MCSFR_PWR_PD_BIT 1
`define MCSFR_PWR_IDL_BIT 0
`define MCSFR_PWR_MASK 8'hDF
`define MCSFR_PROG_RST_BIT 7
`define MCSFR_PROG_BOOT_BIT 1
`define MCSFR_PROG_EN_BIT 0
`define MCSFR_XIC_MASK 8'h03
`define MCSFR_TIMER_TWO_CONTROL_REG_MASK 8'hCD
`define MCSFR_COUNTER_ARRAY_MODE_MASK 8'hC7
`define MCSFR_RST_BYTE 8'h00
`define MCSFR_RST_PSW 8'h00
`define MCSFR_TA_KEY1 8'hAA
`define MCSFR_TA_KEY2 8'h55
`define MCSFR_TA_OPEN_CYCLES 4
`define MCSFR_AUX_TOP 16'h03FF
`define MCSFR_IRAM_SFR_BASE 8'h80
`define MCSFR_CLOCK_HZ 25000000
`define MCSFR_OSC_PER_MC 12
`define MCSFR_RST_HOLD_MC 2
`define MCSFR_SWRST_CYCLES 24
`endif

/* File: rtl/mcsfr_pkg.sv */
// Types shared by the register bank and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package mcsfr_pkg;
	typedef enum logic [1:0] {
		TA_LOCKED = 2'b00,
		TA_KEYED = 2'b01,
		TA_OPEN = 2'b10
	} mcsfr_ta_type;
	typedef enum logic [1:0] {
		RC_RUN = 2'b00,
		RC_PIN = 2'b01,
		RC_SOFT = 2'b10
	} mcsfr_rst_type;
endpackage : mcsfr_pkg

/* File: rtl/mcsfr_if.sv */
// Bundles between the register bank and its reset and routing helpers.
// Assumes all signals belong to core_clk_i.
`timescale 1ns/1ns
interface mcsfr_rst_if;
	logic pin_level;
	logic soft_req;
	logic dev_rst;
	logic reboot_busy;
	modport ctl(input pin_level, input soft_req, output dev_rst, output reboot_busy);
	modport bank(output pin_level, output soft_req, input dev_rst, input reboot_busy);
endinterface : mcsfr_rst_if

interface mcsfr_route_if;
	logic aux_en;
	logic [4:0] bank_base;
	logic iram_direct;
	logic [7:0] iram_addr;
	logic xmove_req;
	logic xmove_ri;
	logic [15:0] xmove_addr;
	logic code_internal;
	logic iram_sel;
	logic sfr_sel;
	logic [7:0] ptr_addr;
	logic aux_sel;
	logic ext_sel;
	logic ports_touch;
	modport route(input aux_en, input bank_base, input iram_direct, input iram_addr, input xmove_req,
		input xmove_ri, input xmove_addr, input code_internal, output iram_sel, output sfr_sel,
		output ptr_addr, output aux_sel, output ext_sel, output ports_touch);
	modport bank(output aux_en, output bank_base, output iram_direct, output iram_addr, output xmove_req,
		output xmove_ri, output xmove_addr, output code_internal, input iram_sel, input sfr_sel,
		input ptr_addr, input aux_sel, input ext_sel, input ports_touch);
endinterface : mcsfr_route_if

/* File: rtl/mcsfr_reset_ctl.sv */
// Reset pin qualifier and software reboot sequencer.
// Assumes the pin level is already synchronous to core_clk_i.
`timescale 1ns/1ns
`include "mcsfr_cfg.svh"
module mcsfr_reset_ctl #(
	parameter int HOLD_CYCLES = `MCSFR_OSC_PER_MC * `MCSFR_RST_HOLD_MC,
	parameter int SOFT_CYCLES = `MCSFR_SWRST_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	mcsfr_rst_if.ctl rst_if
);
	initial begin
		if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255 || SOFT_CYCLES < 1 || SOFT_CYCLES > 255) begin
			$error("mcsfr_reset_ctl: counts must be 1..255");
		end
	end
	mcsfr_pkg::mcsfr_rst_type state_q;
	logic [7:0] cnt_q;
	logic [7:0] hold_q;
	// Pin must stay high for two machine cycles
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i || !rst_if.pin_level) begin
			hold_q <= 8'h00;
		end else if (hold_q != 8'(HOLD_CYCLES)) begin
			hold_q <= hold_q + 8'h01; // (R22)
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			state_q <= mcsfr_pkg::RC_RUN;
			cnt_q <= 8'h00;
		end else begin
			case (state_q)
				mcsfr_pkg::RC_RUN: begin
					if (rst_if.soft_req) begin
						state_q <= mcsfr_pkg::RC_SOFT; // (R12)
						cnt_q <= 8'(SOFT_CYCLES);
					end else if (hold_q == 8'(HOLD_CYCLES)) begin
						state_q <= mcsfr_pkg::RC_PIN; // (R22)
					end
				end
				mcsfr_pkg::RC_PIN: begin
					if (!rst_if.pin_level) begin
						state_q <= mcsfr_pkg::RC_RUN;
					end
				end
				mcsfr_pkg::RC_SOFT: begin
					cnt_q <= cnt_q - 8'h01;
					if (cnt_q == 8'h01) begin
						state_q <= mcsfr_pkg::RC_RUN;
					end
				end
				default: begin
					state_q <= mcsfr_pkg::RC_RUN;
				end
			endcase
		end
	end
	assign rst_if.dev_rst = (state_q != mcsfr_pkg::RC_RUN);
	assign rst_if.reboot_busy = (state_q == mcsfr_pkg::RC_SOFT);
endmodule : mcsfr_reset_ctl

/* File: rtl/mcsfr_addr_route.sv */
// Internal RAM, auxiliary RAM and external data steering.
// Assumes the core presents one access at a time.
`timescale 1ns/1ns
`include "mcsfr_cfg.svh"
module mcsfr_addr_route (
	mcsfr_route_if.route rt
);
	logic aux_hit;
	// Direct addresses from 80h reach the registers, not RAM
	assign rt.sfr_sel = rt.iram_direct && (rt.iram_addr >= `MCSFR_IRAM_SFR_BASE); // (R2)
	assign rt.iram_sel = !rt.sfr_sel; // (R2)
	// Pointer register R0 or R1 of the selected bank
	assign rt.ptr_addr = {3'b000, rt.bank_base} | {7'h00, rt.iram_addr[0]}; // (R2)
	assign aux_hit = rt.xmove_ri || (rt.xmove_addr <= `MCSFR_AUX_TOP); // (R3) (R4)
	assign rt.aux_sel = rt.xmove_req && rt.aux_en && aux_hit; // (R1) (R3) (R4)
	assign rt.ext_sel = rt.xmove_req && !rt.aux_sel; // (R3)
	// Ports and strobes stay quiet for auxiliary access from internal code
	assign rt.ports_touch = rt.ext_sel || (rt.aux_sel && !rt.code_internal); // (R5)
endmodule : mcsfr_addr_route

/* File: rtl/mcsfr_sfr_bank.sv */
// Special-function register bank with Avalon-MM slave, Timer 2 and status word.
// Assumes the core drives ALU, accumulator and access requests on core_clk_i.
// Behaviour
// (R1) Auxiliary RAM enabled while aux control bit 1 is 0, enabled after reset.
// (R2) Direct addresses below 80h and all indirect ones reach RAM via R0/R1.
// (R3) External moves up to 3FFh go to auxiliary RAM, above to external memory.
// (R4) With auxiliary RAM on, an 8-bit pointer move always targets it.
// (R5) Internal-code auxiliary accesses leave ports 0, 2 and strobes alone.
// (R6) Port 0 pull-up bit: 0 open-drain, 1 pulled up.
// (R7) Power control bit 7 doubles serial baud rate in modes 1 to 3.
// (R8) Frame error enable picks serial control bit 7 meaning.
// (R9) Power-on flag set by power-on reset, cleared by software.
// (R10) Bit 1 enters power-down, bit 0 idle; bits 3 and 2 are flags.
// (R11) Mask bits choose compared address bits; interrupt only on full match.
// (R12) With boot select and program enable set, bit 7 write reboots; read shows busy.
// (R13) Boot select chooses loader location and reprogram target.
// (R14) Program enable allows flash operations in idle, otherwise read-only.
// (R15) Programming control reads freely; writes need the timed-access sequence.
// (R16) Timer 2 output enable gates the clock-out function.
// (R17) Down-count enable lets the external pin steer auto-reload direction.
// (R18) Reload pair captures count in capture mode, reloads in auto-reload mode.
// (R19) Carry, aux carry and overflow follow ALU carries; overflow is c6 xor c7.
// (R20) Parity bit shows odd number of ones in the accumulator.
// (R21) Bank select maps registers to four eight-byte regions from 00h.
// (R22) Reset pin high two machine cycles resets the device.
// (R23) Byte access in one bus cycle (the bank adds one wait cycle); reserved bits read zero, ignore writes.
`timescale 1ns/1ns
`include "mcsfr_cfg.svh"
module mcsfr_sfr_bank (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [7:0] avs_writedata_i,
	output logic [7:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic reset_pin_i,
	output logic device_reset_o,
	input wire logic [7:0] acc_i,
	input wire logic alu_flag_we_i,
	input wire logic alu_carry_i,
	input wire logic alu_carry3_i,
	input wire logic alu_carry6_i,
	input wire logic alu_carry7_i,
	output logic [4:0] bank_base_o,
	input wire logic iram_direct_i,
	input wire logic [7:0] iram_addr_i,
	output logic iram_sel_o,
	output logic sfr_sel_o,
	output logic [7:0] ptr_addr_o,
	input wire logic xmove_req_i,
	input wire logic xmove_ri_i,
	input wire logic [15:0] xmove_addr_i,
	input wire logic code_internal_i,
	output logic aux_sel_o,
	output logic ext_sel_o,
	output logic ports_touch_o,
	output logic p0_pullup_en_o,
	output logic baud_double_o,
	output logic frame_error_enable_o,
	output logic power_down_o,
	output logic idle_o,
	input wire logic wake_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_addr_valid_i,
	output logic addr_match_o,
	output logic boot_location_o,
	output logic flash_program_en_o,
	output logic isp_active_o,
	input wire logic t2_tick_i,
	input wire logic t2_ext_pin_i,
	output logic t2_clock_out_o
);
	function automatic logic f_hit(input logic [7:0] addr, input logic [7:0] off);
		f_hit = (addr == off);
	endfunction : f_hit

	mcsfr_rst_if rst_if();
	mcsfr_route_if rt();
	mcsfr_reset_ctl u_reset (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.rst_if(rst_if.ctl)
	);
	mcsfr_addr_route u_route (
		.rt(rt.route)
	);

	logic ack_q;
	logic req;
	logic wr_go;
	logic srst;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic [7:0] aux_q;
	logic [7:0] port0_pullup_ctrl_q;
	logic [7:0] pwr_q;
	logic [7:0] slave_address_q;
	logic [7:0] smask_q;
	logic [1:0] prog_q;
	logic [7:0] xic_q;
	logic [7:0] timer_two_control_reg_q;
	logic [15:0] rld_q;
	logic [15:0] cnt_q;
	logic [7:0] psw_q;
	logic [7:0] counter_array_mode_q;
	logic match_q;
	logic clkout_q;
	logic ext_q;
	mcsfr_pkg::mcsfr_ta_type ta_q;
	logic [2:0] ta_cnt_q;
	logic ta_ok;
	logic ext_fall;
	logic t2_step;
	logic t2_down;
	logic t2_ovf;
	logic t2_cap_mode;
	logic [15:0] cnt_next;

	// One wait cycle, then the access completes
	assign req = avs_read_i || avs_write_i;
	assign avs_waitrequest_o = req && !ack_q; // (R23)
	assign wr_go = avs_write_i && ack_q;
	assign srst = !rst_b_i || rst_if.dev_rst;
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q; // (R23)
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		case (avs_address_i)
			`MCSFR_OFF_AUX: rdata_d = aux_q;
			`MCSFR_OFF_PORT0_PULLUP_CTRL: rdata_d = port0_pullup_ctrl_q;
			`MCSFR_OFF_PWR: rdata_d = pwr_q;
			`MCSFR_OFF_SLAVE_ADDRESS: rdata_d = slave_address_q;
			`MCSFR_OFF_SMASK: rdata_d = smask_q;
			`MCSFR_OFF_PROG: rdata_d = {rst_if.reboot_busy, 5'b00000, prog_q}; // (R12) (R15)
			`MCSFR_OFF_XIC: rdata_d = xic_q;
			`MCSFR_OFF_TIMER_TWO_CONTROL_REG: rdata_d = timer_two_control_reg_q;
			`MCSFR_OFF_RLDL: rdata_d = rld_q[7:0];
			`MCSFR_OFF_RLDH: rdata_d = rld_q[15:8];
			`MCSFR_OFF_CNTL: rdata_d = cnt_q[7:0];
			`MCSFR_OFF_CNTH: rdata_d = cnt_q[15:8];
			`MCSFR_OFF_PSW: rdata_d = {psw_q[7:1], ^acc_i}; // (R20)
			`MCSFR_OFF_COUNTER_ARRAY_MODE: rdata_d = counter_array_mode_q;
			default: rdata_d = 8'h00; // (R23)
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rdata_q <= 8'h00;
		end else if (avs_read_i && !ack_q) begin
			rdata_q <= rdata_d; // (R23)
		end
	end
	assign avs_readdata_o = rdata_q;

	// Timed access: key bytes open a short write window
	assign ta_ok = (ta_q == mcsfr_pkg::TA_OPEN);
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			ta_q <= mcsfr_pkg::TA_LOCKED;
			ta_cnt_q <= 3'h0;
		end else begin
			case (ta_q)
				mcsfr_pkg::TA_LOCKED: begin
					if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_TAKEY) && avs_writedata_i == `MCSFR_TA_KEY1) begin
						ta_q <= mcsfr_pkg::TA_KEYED;
					end
				end
				mcsfr_pkg::TA_KEYED: begin
					if (wr_go) begin
						if (f_hit(avs_address_i, `MCSFR_OFF_TAKEY) && avs_writedata_i == `MCSFR_TA_KEY2) begin
							ta_q <= mcsfr_pkg::TA_OPEN; // (R15)
							ta_cnt_q <= 3'(`MCSFR_TA_OPEN_CYCLES);
						end else begin
							ta_q <= mcsfr_pkg::TA_LOCKED;
						end
					end
				end
				mcsfr_pkg::TA_OPEN: begin
					ta_cnt_q <= ta_cnt_q - 3'h1;
					if (wr_go || ta_cnt_q == 3'h1) begin
						ta_q <= mcsfr_pkg::TA_LOCKED; // (R15)
					end
				end
				default: begin
					ta_q <= mcsfr_pkg::TA_LOCKED;
				end
			endcase
		end
	end

	// Programming control keeps its setting across a reboot
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			prog_q <= 2'b00;
		end else if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_PROG) && ta_ok) begin
			prog_q <= {avs_writedata_i[`MCSFR_PROG_BOOT_BIT], avs_writedata_i[`MCSFR_PROG_EN_BIT]}; // (R13) (R14) (R15)
		end
	end
	assign rst_if.soft_req = wr_go && f_hit(avs_address_i, `MCSFR_OFF_PROG) && ta_ok
		&& avs_writedata_i[`MCSFR_PROG_RST_BIT] && (prog_q == 2'b11); // (R12)
	assign rst_if.pin_level = reset_pin_i;
	assign device_reset_o = rst_if.dev_rst; // (R22)

	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			aux_q <= `MCSFR_RST_BYTE; // (R1)
			port0_pullup_ctrl_q <= `MCSFR_RST_BYTE;
			slave_address_q <= `MCSFR_RST_BYTE;
			smask_q <= `MCSFR_RST_BYTE;
			xic_q <= `MCSFR_RST_BYTE;
			counter_array_mode_q <= `MCSFR_RST_BYTE;
		end else if (wr_go) begin
			if (f_hit(avs_address_i, `MCSFR_OFF_AUX)) begin
				aux_q <= avs_writedata_i & 8'h02; // (R1) (R23)
			end
			if (f_hit(avs_address_i, `MCSFR_OFF_PORT0_PULLUP_CTRL)) begin
				port0_pullup_ctrl_q <= avs_writedata_i & 8'h01; // (R6) (R23)
			end
			if (f_hit(avs_address_i, `MCSFR_OFF_SLAVE_ADDRESS)) begin
				slave_address_q <= avs_writedata_i;
			end
			if (f_hit(avs_address_i, `MCSFR_OFF_SMASK)) begin
				smask_q <= avs_writedata_i;
			end
			if (f_hit(avs_address_i, `MCSFR_OFF_XIC)) begin
				xic_q <= avs_writedata_i & `MCSFR_XIC_MASK; // (R23)
			end
			if (f_hit(avs_address_i, `MCSFR_OFF_COUNTER_ARRAY_MODE)) begin
				counter_array_mode_q <= avs_writedata_i & `MCSFR_COUNTER_ARRAY_MODE_MASK; // (R23)
			end
		end
	end

	// Power control; the power-on flag survives pin and software resets
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pwr_q <= 8'h00 | (8'h01 << `MCSFR_PWR_POF_BIT); // (R9)
		end else if (rst_if.dev_rst) begin
			pwr_q <= pwr_q & (8'h01 << `MCSFR_PWR_POF_BIT);
		end else if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_PWR)) begin
			pwr_q <= avs_writedata_i & `MCSFR_PWR_MASK; // (R9) (R10) (R23)
		end else if (wake_i) begin
			pwr_q[`MCSFR_PWR_PD_BIT] <= 1'b0;
			pwr_q[`MCSFR_PWR_IDL_BIT] <= 1'b0;
		end
	end
	assign baud_double_o = pwr_q[`MCSFR_PWR_BAUD_BIT]; // (R7)
	assign frame_error_enable_o = pwr_q[`MCSFR_PWR_FE_BIT]; // (R8)
	assign power_down_o = pwr_q[`MCSFR_PWR_PD_BIT]; // (R10)
	assign idle_o = pwr_q[`MCSFR_PWR_IDL_BIT]; // (R10)
	assign p0_pullup_en_o = port0_pullup_ctrl_q[0]; // (R6)
	assign boot_location_o = prog_q[1]; // (R13)
	assign flash_program_en_o = prog_q[0]; // (R14)
	assign isp_active_o = prog_q[0] && pwr_q[`MCSFR_PWR_IDL_BIT]; // (R14)

	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			match_q <= 1'b0;
		end else begin
			match_q <= rx_addr_valid_i && (((rx_byte_i ^ slave_address_q) & smask_q) == 8'h00); // (R11)
		end
	end
	assign addr_match_o = match_q;

	// Status word: hardware flag update wins over a bus write
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			psw_q <= `MCSFR_RST_PSW;
		end else if (alu_flag_we_i) begin
			psw_q[7] <= alu_carry_i; // (R19)
			psw_q[6] <= alu_carry3_i; // (R19)
			psw_q[2] <= alu_carry6_i ^ alu_carry7_i; // (R19)
		end else if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_PSW)) begin
			psw_q <= {avs_writedata_i[7:1], 1'b0};
		end
	end
	assign bank_base_o = {psw_q[4:3], 3'b000}; // (R21)

	// Timer 2
	assign t2_cap_mode = timer_two_control_reg_q[0];
	assign ext_fall = ext_q && !t2_ext_pin_i;
	assign t2_step = t2_tick_i && timer_two_control_reg_q[2];
	assign t2_down = xic_q[0] && !t2_cap_mode && !t2_ext_pin_i; // (R17)
	assign t2_ovf = t2_step && (t2_down ? (cnt_q == rld_q) : (cnt_q == 16'hFFFF));
	always_comb begin
		cnt_next = t2_down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
		if (t2_ovf) begin
			cnt_next = t2_down ? 16'hFFFF : (t2_cap_mode ? 16'h0000 : rld_q); // (R17) (R18)
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			ext_q <= 1'b1;
		end else begin
			ext_q <= t2_ext_pin_i;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			cnt_q <= 16'h0000;
		end else if (!t2_cap_mode && timer_two_control_reg_q[3] && ext_fall) begin
			cnt_q <= rld_q; // (R18)
		end else if (t2_step) begin
			cnt_q <= cnt_next;
		end else if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_CNTL)) begin
			cnt_q[7:0] <= avs_writedata_i;
		end else if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_CNTH)) begin
			cnt_q[15:8] <= avs_writedata_i;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			rld_q <= 16'h0000;
		end else if (t2_cap_mode && timer_two_control_reg_q[3] && ext_fall) begin
			rld_q <= cnt_q; // (R18)
		end else if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_RLDL)) begin
			rld_q[7:0] <= avs_writedata_i;
		end else if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_RLDH)) begin
			rld_q[15:8] <= avs_writedata_i;
		end
	end
	// Overflow and external flags: set beats software clear
	always_ff @(posedge core_clk_i) begin
		if (srst) begin
			timer_two_control_reg_q <= `MCSFR_RST_BYTE;
		end else begin
			if (wr_go && f_hit(avs_address_i, `MCSFR_OFF_TIMER_TWO_CONTROL_REG)) begin
				timer_two_control_reg_q <= avs_writedata_i & `MCSFR_TIMER_TWO_CONTROL_REG_MASK;
			end
			if (t2_ovf) begin
				timer_two_control_reg_q[7] <= 1'b1;
			end
			if (timer_two_control_reg_q[3] && ext_fall) begin
				timer_two_control_reg_q[6] <= 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst || !xic_q[1]) begin
			clkout_q <= 1'b0; // (R16)
		end else if (t2_ovf) begin
			clkout_q <= !clkout_q; // (R16)
		end
	end
	assign t2_clock_out_o = clkout_q;

	assign rt.aux_en = !aux_q[`MCSFR_AUX_DIS_BIT]; // (R1)
	assign rt.bank_base = bank_base_o;
	assign rt.iram_direct = iram_direct_i;
	assign rt.iram_addr = iram_addr_i;
	assign rt.xmove_req = xmove_req_i;
	assign rt.xmove_ri = xmove_ri_i;
	assign rt.xmove_addr = xmove_addr_i;
	assign rt.code_internal = code_internal_i;
	assign iram_sel_o = rt.iram_sel;
	assign sfr_sel_o = rt.sfr_sel;
	assign ptr_addr_o = rt.ptr_addr;
	assign aux_sel_o = rt.aux_sel;
	assign ext_sel_o = rt.ext_sel;
	assign ports_touch_o = rt.ports_touch;
endmodule : mcsfr_sfr_bank

/* File: verification/mcsfr_sfr_bank_assertions.sv */
// Port-level checks of the register bank.
// Assumes one clock domain; bound to every bank instance below.
`timescale 1ns/1ns
module mcsfr_sfr_bank_assertions (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [7:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	input wire logic reset_pin_i,
	input wire logic device_reset_o,
	input wire logic [4:0] bank_base_o,
	input wire logic [7:0] iram_addr_i,
	input wire logic [7:0] ptr_addr_o,
	input wire logic xmove_req_i,
	input wire logic xmove_ri_i,
	input wire logic [15:0] xmove_addr_i,
	input wire logic aux_sel_o,
	input wire logic ext_sel_o,
	input wire logic p0_pullup_en_o,
	input wire logic baud_double_o,
	input wire logic frame_error_enable_o,
	input wire logic power_down_o,
	input wire logic idle_o,
	input wire logic wake_i
);
	logic [7:0] wd_q;
	logic aux_dis_q;
	logic [4:0] pin_q;
	wire logic wack = avs_write_i && !avs_waitrequest_o;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	always_ff @(posedge core_clk_i) begin
		wd_q <= avs_writedata_i;
	end
	// Tracks the auxiliary RAM disable bit as written
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i || device_reset_o) begin
			aux_dis_q <= 1'h0;
		end else if (wack && avs_address_i == 8'h8E) begin
			aux_dis_q <= avs_writedata_i[1];
		end
	end
	// Consecutive cycles with the reset pin high
	always_ff @(posedge core_clk_i) begin
		if (!reset_pin_i) begin
			pin_q <= 5'h00;
		end else if (pin_q != 5'h1F) begin
			pin_q <= pin_q + 5'h01;
		end
	end
	property p_wait;
		$rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("access not one wait cycle");
	property p_pullup;
		wack && avs_address_i == 8'h86 |=> p0_pullup_en_o == wd_q[0];
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up select wrong");
	property p_baud;
		wack && avs_address_i == 8'h87 |=> baud_double_o == wd_q[7] && frame_error_enable_o == wd_q[6];
	endproperty
	a_baud: assert property (p_baud) else $error("serial bits wrong");
	property p_wake;
		wake_i |=> !power_down_o && !idle_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake left power bits");
	property p_bank;
		wack && avs_address_i == 8'hD0 |=> bank_base_o == {wd_q[4:3], 3'h0};
	endproperty
	a_bank: assert property (p_bank) else $error("bank base wrong");
	property p_ptr;
		ptr_addr_o == ({3'h0, bank_base_o} | {7'h00, iram_addr_i[0]});
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer address wrong");
	property p_ext;
		xmove_req_i && !xmove_ri_i && xmove_addr_i > 16'h03FF |-> ext_sel_o && !aux_sel_o;
	endproperty
	a_ext: assert property (p_ext) else $error("high move not external");
	property p_ri;
		xmove_req_i && xmove_ri_i && !aux_dis_q |-> aux_sel_o && !ext_sel_o;
	endproperty
	a_ri: assert property (p_ri) else $error("pointer move not auxiliary");
	property p_pin;
		reset_pin_i && pin_q == 5'h17 |-> ##[1:2] device_reset_o;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset missing");
	c_read: cover property (avs_read_i && !avs_waitrequest_o);
	c_reset: cover property ($rose(device_reset_o));
	c_aux: cover property (xmove_req_i && aux_sel_o);
endmodule : mcsfr_sfr_bank_assertions

bind mcsfr_sfr_bank mcsfr_sfr_bank_assertions u_chk (.*);

/* File: verification/tb.sv */
// Self-checking bench driving the register bank through its Avalon-MM slave.
// Assumes the bank answers each access after one wait cycle.
`timescale 1ns/1ns
module tb;
	logic core_clk_i = 1'h0, rst_b_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0, reset_pin_i = 1'h0;
	logic alu_flag_we_i = 1'h0, alu_carry_i = 1'h0, alu_carry3_i = 1'h0, alu_carry6_i = 1'h0, alu_carry7_i = 1'h0;
	logic iram_direct_i = 1'h0, xmove_req_i = 1'h0, xmove_ri_i = 1'h0, code_internal_i = 1'h0, wake_i = 1'h0;
	logic rx_addr_valid_i = 1'h0, t2_tick_i = 1'h0, t2_ext_pin_i = 1'h0;
	logic [7:0] avs_address_i = 8'h00, avs_writedata_i = 8'h00, acc_i = 8'h07, iram_addr_i = 8'h01;
	logic [7:0] rx_byte_i = 8'h00, avs_readdata_o, ptr_addr_o, rv;
	logic [15:0] xmove_addr_i = 16'h03FF;
	logic [4:0] bank_base_o;
	logic avs_waitrequest_o, device_reset_o, iram_sel_o, sfr_sel_o, aux_sel_o, ext_sel_o, ports_touch_o;
	logic p0_pullup_en_o, baud_double_o, frame_error_enable_o, power_down_o, idle_o, addr_match_o;
	logic boot_location_o, flash_program_en_o, isp_active_o, t2_clock_out_o;
	int failures = 0;
	int n_checks = 0;
	localparam logic [7:0] WA [7] = '{8'h86, 8'hC0, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD9};
	localparam logic [7:0] WX [7] = '{8'h01, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC7};
	mcsfr_sfr_bank u_dut (.core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_readdata_o, .avs_waitrequest_o, .reset_pin_i, .device_reset_o, .acc_i, .alu_flag_we_i, .alu_carry_i,
		.alu_carry3_i, .alu_carry6_i, .alu_carry7_i, .bank_base_o, .iram_direct_i, .iram_addr_i, .iram_sel_o,
		.sfr_sel_o, .ptr_addr_o, .xmove_req_i, .xmove_ri_i, .xmove_addr_i, .code_internal_i, .aux_sel_o,
		.ext_sel_o, .ports_touch_o, .p0_pullup_en_o, .baud_double_o, .frame_error_enable_o, .power_down_o,
		.idle_o, .wake_i, .rx_byte_i, .rx_addr_valid_i, .addr_match_o, .boot_location_o, .flash_program_en_o,
		.isp_active_o, .t2_tick_i, .t2_ext_pin_i, .t2_clock_out_o);
	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	task automatic print_verdict();
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge core_clk_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		i = 0;
		do begin
			@(posedge core_clk_i);
			i++;
		end while (avs_waitrequest_o !== 1'h0 && i < 20);
		rv = avs_readdata_o;
		avs_write_i <= 1'h0;
		avs_read_i <= 1'h0;
		chk(i < 20, 1'h1);
		if (i >= 20) begin
			print_verdict();
		end
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'h1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'h0, a, 8'h00);
		chk(rv, e);
	endtask : rd
	task automatic rst_wait();
		int i;
		i = 0;
		while (device_reset_o !== 1'h0 && i < 100) begin
			@(posedge core_clk_i);
			i++;
		end
		chk(i < 100, 1'h1);
		if (i >= 100) begin
			print_verdict();
		end
	endtask : rst_wait
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_b_i <= 1'h1;
		rd(8'h87, 8'h10);
		rd(8'h81, 8'h00);
		for (int k = 0; k < 7; k++) begin
			wr(WA[k], 8'hFF);
			rd(WA[k], WX[k]);
		end
		wr(8'h87, 8'hCC);
		rd(8'h87, 8'hCC);
		@(negedge core_clk_i);
		chk({p0_pullup_en_o, baud_double_o, frame_error_enable_o}, 3'h7);
		wr(8'hBF, 8'h03);
		rd(8'hBF, 8'h00);
		wr(8'hC7, 8'hAA);
		wr(8'hC7, 8'h55);
		wr(8'hBF, 8'h03);
		rd(8'hBF, 8'h03);
		wr(8'h87, 8'h03);
		@(negedge core_clk_i);
		chk({boot_location_o, flash_program_en_o, isp_active_o, power_down_o, idle_o}, 5'h1F);
		@(posedge core_clk_i);
		wake_i <= 1'h1;
		@(posedge core_clk_i);
		wake_i <= 1'h0;
		@(negedge core_clk_i);
		chk({isp_active_o, power_down_o, idle_o}, 3'h0);
		wr(8'hC7, 8'hAA);
		wr(8'hC7, 8'h55);
		wr(8'hBF, 8'h83);
		@(negedge core_clk_i);
		chk(device_reset_o, 1'h1);
		acc(1'h0, 8'hBF, 8'h00);
		chk(rv[7], 1'h1);
		rst_wait();
		rd(8'h86, 8'h00);
		for (int b = 0; b < 4; b++) begin
			wr(8'hD0, 8'(b * 8));
			rd(8'hD0, 8'(b * 8 + 1));
			@(negedge core_clk_i);
			chk({bank_base_o, ptr_addr_o}, {5'(b * 8), 8'(b * 8 + 1)});
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk_i);
			acc_i <= 8'h03;
			alu_flag_we_i <= 1'h1;
			{alu_carry_i, alu_carry3_i, alu_carry6_i, alu_carry7_i} <= {3'h7, k[0]};
			@(posedge core_clk_i);
			alu_flag_we_i <= 1'h0;
			rd(8'hD0, k ? 8'hD8 : 8'hDC);
		end
		@(posedge core_clk_i);
		{iram_direct_i, xmove_req_i} <= 2'h3;
		iram_addr_i <= 8'h90;
		@(negedge core_clk_i);
		chk({sfr_sel_o, iram_sel_o, aux_sel_o, ext_sel_o}, 4'hA);
		@(posedge core_clk_i);
		iram_direct_i <= 1'h0;
		xmove_addr_i <= 16'h0400;
		@(negedge core_clk_i);
		chk({sfr_sel_o, iram_sel_o, aux_sel_o, ext_sel_o, ports_touch_o}, 5'h0B);
		@(posedge core_clk_i);
		{xmove_ri_i, code_internal_i} <= 2'h3;
		@(negedge core_clk_i);
		chk({aux_sel_o, ext_sel_o, ports_touch_o}, 3'h4);
		wr(8'h8E, 8'h02);
		@(negedge core_clk_i);
		chk({aux_sel_o, ext_sel_o}, 2'h1);
		@(posedge core_clk_i);
		xmove_req_i <= 1'h0;
		wr(8'hA9, 8'h5A);
		wr(8'hB9, 8'hF0);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk_i);
			rx_byte_i <= k ? 8'h43 : 8'h53;
			rx_addr_valid_i <= 1'h1;
			@(posedge core_clk_i);
			rx_addr_valid_i <= 1'h0;
			@(negedge core_clk_i);
			chk(addr_match_o, k == 0);
		end
		wr(8'h86, 8'h01);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk_i);
			reset_pin_i <= 1'h1;
			repeat (k ? 26 : 10) @(posedge core_clk_i);
			@(negedge core_clk_i);
			chk(device_reset_o, k[0]);
			@(posedge core_clk_i);
			reset_pin_i <= 1'h0;
		end
		rst_wait();
		rd(8'h86, 8'h00);
		// Timer 2: up to overflow and reload, then down through the reload value
		wr(8'hC0, 8'h02);
		wr(8'hCA, 8'h34);
		wr(8'hCB, 8'h12);
		wr(8'hCC, 8'hFE);
		wr(8'hCD, 8'hFF);
		wr(8'hC8, 8'h04);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk_i);
			t2_tick_i <= 1'h1;
			repeat (2) @(posedge core_clk_i);
			t2_tick_i <= 1'h0;
			@(negedge core_clk_i);
			chk(t2_clock_out_o, !k[0]);
			rd(8'hCC, k ? 8'hFE : 8'h34);
			wr(8'hC0, 8'h03);
		end
		print_verdict();
	end
endmodule : tb
